// *** common/fp_status_pkg.sv ***
// Shared constants and types for the floating-point status register and
// the packed-decimal operand classifier.
// Assumes one clock domain and a datapath that reports result flags.
package fp_status_pkg;

	// ------------------------------------------------------------
	// Status register field positions
	// ------------------------------------------------------------
	localparam int unsigned EXTRAS_BIT   = 0;
	localparam int unsigned REV_LSB      = 1;
	localparam int unsigned REV_MSB      = 3;
	localparam int unsigned MISALIGN_BIT = 4;
	localparam int unsigned PREM_BIT     = 5;
	localparam int unsigned DIV0_S_BIT   = 6;
	localparam int unsigned UNDER_S_BIT  = 7;
	localparam int unsigned OVER_S_BIT   = 8;
	localparam int unsigned BADOP_S_BIT  = 9;
	localparam int unsigned INEX_M_BIT   = 10;
	localparam int unsigned DIV0_M_BIT   = 11;
	localparam int unsigned UNDER_M_BIT  = 12;
	localparam int unsigned OVER_M_BIT   = 13;
	localparam int unsigned BADOP_M_BIT  = 14;
	localparam int unsigned WFAULT_BIT   = 15;
	localparam int unsigned UNORD_BIT    = 16;
	localparam int unsigned CTXSW_BIT    = 17;
	localparam int unsigned INEX_S_BIT   = 18;
	localparam int unsigned INTOVF_BIT   = 19;
	localparam int unsigned ZERO_BIT     = 20;
	localparam int unsigned NEG_BIT      = 21;
	localparam int unsigned RSEL_LSB     = 22;
	localparam int unsigned RSEL_MSB     = 23;
	localparam int unsigned QTRAP_BIT    = 24;
	localparam int unsigned EXCP_BIT     = 25;
	localparam int unsigned RESV_LSB     = 26;
	localparam int unsigned RESV_MSB     = 30;
	localparam int unsigned READY_BIT    = 31;

	// Bits that a status write may change; revision, exception summary
	// and reserved bits are never stored
	localparam logic [31:0] WRITE_MASK   = 32'h81ff_fff1;
	localparam logic [31:0] STATUS_RESET = 32'h8000_0000;
	// Revision code value is arbitrary
	localparam logic [2:0]  REVISION_DEF = 3'h6;

	// ------------------------------------------------------------
	// Decimal operand layout
	// ------------------------------------------------------------
	localparam int unsigned DEC_WIDTH    = 96;
	localparam int unsigned DEC_USED     = 76;
	localparam int unsigned DEC_DIGITS   = 18;
	localparam int unsigned SIGN_BITS    = 4;
	localparam int unsigned INT_WIDTH    = 32;
	localparam logic [3:0]  SIGN_PINF    = 4'h0;
	localparam logic [3:0]  SIGN_NINF    = 4'h1;
	localparam logic [3:0]  SIGN_PQNAN   = 4'h2;
	localparam logic [3:0]  SIGN_NQNAN   = 4'h3;
	localparam logic [3:0]  SIGN_TRAP_LO = 4'h4;
	localparam logic [3:0]  SIGN_TRAP_HI = 4'h9;
	localparam logic [3:0]  SIGN_NUM_LO  = 4'ha;
	localparam logic [3:0]  SIGN_NEG_A   = 4'hb;
	localparam logic [3:0]  SIGN_NEG_B   = 4'hd;
	localparam logic [3:0]  DIGIT_MAX    = 4'h9;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP, OP_STATUS_READ, OP_STATUS_WRITE, OP_LOAD_DATA,
		OP_ERROR_FETCH, OP_ARITH, OP_COMPARE, OP_CONV_INT
	} op_t;

	typedef struct packed {
		logic zero;
		logic neg;
		logic inexact;
		logic underflow;
		logic overflow;
		logic invalid;
		logic divisor_zero;
		logic dividend_finite_nz;
		logic unordered;
		logic int_overflow;
		logic partial_rem;
	} res_flags_t;

	typedef struct packed {
		logic pos_inf;
		logic neg_inf;
		logic quiet_nan;
		logic trap_nan;
		logic number;
		logic negative;
	} dec_class_t;

	typedef struct packed {
		logic neg;
		logic zero;
		logic ovf;
		logic carry;
	} cond_flags_t;

endpackage

// *** src/bcd_classify.sv ***
// Combinational classifier for the packed-decimal operand format.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
module bcd_classify
	import fp_status_pkg::*;
(
	input  wire logic [DEC_WIDTH-1:0] operand_i,
	output dec_class_t                class_o,
	output logic [DEC_WIDTH-1:0]      clean_o
);

	logic [3:0]               sign_nib;
	logic [DEC_DIGITS*4-1:0]  bcd_digits;
	logic                     bad_digit;
	logic                     in_num;
	logic                     trap_rng;

	// Lowest digit nibble is least significant, the top one most
	assign sign_nib   = operand_i[SIGN_BITS-1:0];
	assign bcd_digits = operand_i[DEC_USED-1:SIGN_BITS];

	always_comb begin
		bad_digit = 1'b0;
		for (int i = 0; i < DEC_DIGITS; i++) begin
			if (bcd_digits[i*4 +: 4] > DIGIT_MAX) begin
				bad_digit = 1'b1;
			end
		end
	end

	assign in_num   = (sign_nib >= SIGN_NUM_LO);
	assign trap_rng = (sign_nib >= SIGN_TRAP_LO) && (sign_nib <= SIGN_TRAP_HI);

	assign class_o.pos_inf   = (sign_nib == SIGN_PINF);
	assign class_o.neg_inf   = (sign_nib == SIGN_NINF);
	assign class_o.quiet_nan = (sign_nib == SIGN_PQNAN)
		|| (sign_nib == SIGN_NQNAN)
		|| (in_num && bad_digit);
	assign class_o.trap_nan  = trap_rng;
	assign class_o.number    = in_num && !bad_digit;
	// Sign of numbers and of the two coded quiet NaNs
	assign class_o.negative  = (sign_nib == SIGN_NQNAN)
		|| (in_num && !bad_digit
			&& (sign_nib == SIGN_NEG_A || sign_nib == SIGN_NEG_B));

	assign clean_o = {{(DEC_WIDTH-DEC_USED){1'b0}},
		operand_i[DEC_USED-1:0]};

endmodule // bcd_classify

// *** src/fp_status_ctrl.sv ***
// Floating-point status and control register with operation tracking,
// restart handling after a write fault, and decimal/integer operand decode.
// Assumes the datapath reports one result per started operation and that
// the host issues commands one at a time.
//
// Operation
// - Decimal bits 4..75 hold eighteen digits, top first
// - Sign 0000 plus infinity, 0001 minus infinity
// - Sign 0010/0011 positive/negative quiet NaN
// - Sign four through nine is trapping NaN
// - Number sign with digit above nine: quiet NaN
// - Signs 11,13 negative; 10,12,14,15 positive
// - Decimal bits 76..95 ignored, returned as zero
// - Integer operands are 32-bit two's complement
// - Extras enable gates misaligned and write-fault flags
// - Revision bits 1..3 fixed, writes ignored
// - Misaligned word fault sets bit 4 when enabled
// - Divide-by-zero sticky on zero divisor, finite nonzero dividend
// - Underflow sets bit 7, overflow sets bit 8
// - Invalid operation sets sticky bit 9
// - Mask bits 10..14 enable matching exceptions
// - Write fault sets bit 15 until clean completion
// - Restart under write fault stores transfer data
// - Compare sets unordered bit, else clears it
// - Context bit 17 set by executing instructions
// - Inexact bit 18; after a compare the carry flag shows unordered instead
// - Integer conversion overflow sets unmaskable bit 19
// - Zero and negative bits follow every result
// - Bits 22..23 select the rounding mode
// - Result ready clears on start, sets on result
// - Bit 25 shows any exception condition present
// - Invalid with mask bit 14 clear and quiet-NaN trap bit 24 set raises exception
// - Bits 26..30 read as zero
`timescale 1ns/1ps
module fp_status_ctrl
	import fp_status_pkg::*;
#(
	parameter logic [2:0] REVISION = REVISION_DEF
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 ce_i,
	input  wire logic                 cmd_valid_i,
	input  wire op_t                  cmd_op_i,
	input  wire logic [31:0]          cmd_data_i,
	input  wire logic                 res_valid_i,
	input  wire res_flags_t           res_flags_i,
	input  wire logic                 misaligned_fault_i,
	input  wire logic                 write_fault_i,
	input  wire logic [DEC_WIDTH-1:0] dec_operand_i,
	input  wire logic [INT_WIDTH-1:0] int_operand_i,
	output logic [31:0]               rdata_o,
	output logic                      rdata_valid_o,
	output logic                      start_o,
	output logic                      done_o,
	output logic                      store_xfer_o,
	output logic                      exception_o,
	output logic [1:0]                rounding_sel_o,
	output cond_flags_t               cond_flags_o,
	output dec_class_t                dec_class_o,
	output logic [DEC_WIDTH-1:0]      dec_clean_o,
	output logic                      int_neg_o,
	output logic                      int_zero_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Register access, loads, error fetch and no-op are not instructions
	// that execute, so they neither restart nor set the context bit
	function automatic logic is_exec(input op_t op);
		return (op == OP_ARITH) || (op == OP_COMPARE) || (op == OP_CONV_INT);
	endfunction

	typedef enum logic {ST_IDLE, ST_BUSY} state_t;

	state_t       state;
	state_t       next_state;
	logic [31:0]  status;
	logic [31:0]  next_status;
	logic [31:0]  wr_base;
	logic [31:0]  rd_value;
	logic         last_cmp;
	logic         cur_cmp;
	logic         cur_conv;

	logic         st_rd;
	logic         st_wr;
	logic         exec_cmd;
	logic         restart;
	logic         op_start;
	logic         res_take;
	logic         div0_evt;
	logic         mis_evt;
	logic         wf_evt;
	logic [4:0]   stickies;
	logic [4:0]   masks;
	logic         qtrap_exc;
	logic         excp_now;
	dec_class_t   dec_class;
	logic [DEC_WIDTH-1:0] dec_clean;

	default clocking dflt_cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	assign st_rd    = ce_i && cmd_valid_i && (cmd_op_i == OP_STATUS_READ);
	assign st_wr    = ce_i && cmd_valid_i && (cmd_op_i == OP_STATUS_WRITE);
	assign exec_cmd = ce_i && cmd_valid_i && is_exec(cmd_op_i)
		&& (state == ST_IDLE);
	assign restart  = exec_cmd && status[WFAULT_BIT];
	assign op_start = exec_cmd && !status[WFAULT_BIT];
	assign res_take = ce_i && res_valid_i && (state == ST_BUSY);
	assign div0_evt = res_flags_i.divisor_zero
		&& res_flags_i.dividend_finite_nz;
	// Fault flags only arm while extras are enabled
	assign mis_evt  = ce_i && misaligned_fault_i && status[EXTRAS_BIT];
	assign wf_evt   = ce_i && write_fault_i && status[EXTRAS_BIT];

	// ------------------------------------------------------------
	// Exception summary
	// ------------------------------------------------------------
	assign stickies = {status[BADOP_S_BIT], status[OVER_S_BIT],
		status[UNDER_S_BIT], status[DIV0_S_BIT], status[INEX_S_BIT]};
	assign masks    = status[BADOP_M_BIT:INEX_M_BIT];
	assign qtrap_exc = status[BADOP_S_BIT] && !status[BADOP_M_BIT]
		&& status[QTRAP_BIT];
	assign excp_now = |(stickies & masks)
		|| status[INTOVF_BIT]
		|| qtrap_exc;

	assign rd_value = {status[READY_BIT], 5'h00, excp_now,
		status[QTRAP_BIT:MISALIGN_BIT], REVISION,
		status[EXTRAS_BIT]};

	// ------------------------------------------------------------
	// Next status: write first, then hardware events so sets win
	// ------------------------------------------------------------
	assign wr_base = st_wr ? ((cmd_data_i & WRITE_MASK)
		| (status & ~WRITE_MASK)) : status;

	always_comb begin
		next_status = wr_base;
		if (exec_cmd) begin
			next_status[CTXSW_BIT] = 1'b1;
		end
		if (op_start) begin
			next_status[READY_BIT] = 1'b0;
		end
		if (restart && !wf_evt) begin
			next_status[WFAULT_BIT] = 1'b0;
		end
		if (res_take) begin
			next_status[READY_BIT]   = 1'b1;
			next_status[ZERO_BIT]    = res_flags_i.zero;
			next_status[NEG_BIT]     = res_flags_i.neg;
			next_status[PREM_BIT]    = res_flags_i.partial_rem;
			// Sticky bits only accumulate here
			next_status[DIV0_S_BIT]  |= div0_evt;
			next_status[UNDER_S_BIT] |= res_flags_i.underflow;
			next_status[OVER_S_BIT]  |= res_flags_i.overflow;
			next_status[BADOP_S_BIT] |= res_flags_i.invalid;
			next_status[INEX_S_BIT]  |= res_flags_i.inexact;
			if (cur_cmp) begin
				next_status[UNORD_BIT] = res_flags_i.unordered;
			end
			if (cur_conv) begin
				next_status[INTOVF_BIT] |= res_flags_i.int_overflow;
			end
			if (!wf_evt) begin
				next_status[WFAULT_BIT] = 1'b0;
			end
		end
		if (mis_evt) begin
			next_status[MISALIGN_BIT] = 1'b1;
		end
		if (wf_evt) begin
			next_status[WFAULT_BIT] = 1'b1;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (op_start) begin
					next_state = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (res_take) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state    <= ST_IDLE;
			status   <= STATUS_RESET;
			cur_cmp  <= 1'b0;
			cur_conv <= 1'b0;
			last_cmp <= 1'b0;
		end else if (ce_i) begin
			state  <= next_state;
			status <= next_status;
			if (op_start) begin
				cur_cmp  <= (cmd_op_i == OP_COMPARE);
				cur_conv <= (cmd_op_i == OP_CONV_INT);
			end
			if (res_take) begin
				last_cmp <= cur_cmp;
			end
		end
	end

	// Host-visible strobes and read data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o       <= 32'h0000_0000;
			rdata_valid_o <= 1'b0;
			start_o       <= 1'b0;
			done_o        <= 1'b0;
			store_xfer_o  <= 1'b0;
		end else if (ce_i) begin
			rdata_valid_o <= st_rd;
			if (st_rd) begin
				rdata_o <= rd_value;
			end
			start_o      <= op_start;
			done_o       <= res_take || restart;
			store_xfer_o <= restart;
		end
	end

	assign exception_o    = excp_now;
	assign rounding_sel_o = status[RSEL_MSB:RSEL_LSB];
	// After a compare the carry position carries the unordered state
	assign cond_flags_o   = '{neg: status[NEG_BIT], zero: status[ZERO_BIT],
		ovf: status[INTOVF_BIT],
		carry: last_cmp ? status[UNORD_BIT] : status[INEX_S_BIT]};

	// ------------------------------------------------------------
	// Operand decode
	// ------------------------------------------------------------
	bcd_classify u_bcd (
		.operand_i (dec_operand_i),
		.class_o   (dec_class),
		.clean_o   (dec_clean)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dec_class_o <= '0;
			dec_clean_o <= '0;
			int_neg_o   <= 1'b0;
			int_zero_o  <= 1'b0;
		end else if (ce_i) begin
			dec_class_o <= dec_class;
			dec_clean_o <= dec_clean;
			int_neg_o   <= int_operand_i[INT_WIDTH-1];
			int_zero_o  <= (int_operand_i == '0);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_revision;
		st_rd |=> rdata_o[REV_MSB:REV_LSB] == REVISION;
	endproperty
	a_revision: assert property (p_revision)
		else $error("revision field misread");
	property p_reserved;
		st_rd |=> rdata_valid_o && rdata_o[RESV_MSB:RESV_LSB] == 5'h00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits read nonzero");
	property p_uw_gate;
		$rose(status[MISALIGN_BIT]) && !$past(st_wr)
			|-> $past(status[EXTRAS_BIT]);
	endproperty
	a_uw_gate: assert property (p_uw_gate)
		else $error("misaligned flag set while extras disabled");
	property p_ready_start;
		op_start |=> !status[READY_BIT] && state == ST_BUSY;
	endproperty
	a_ready_start: assert property (p_ready_start)
		else $error("result ready not cleared at start");
	property p_ready_done;
		res_take |=> status[READY_BIT] && done_o ##1 !done_o;
	endproperty
	a_ready_done: assert property (p_ready_done)
		else $error("result ready or done missing after result");
	property p_ctx;
		exec_cmd |=> status[CTXSW_BIT];
	endproperty
	a_ctx: assert property (p_ctx)
		else $error("context bit not set");
	property p_sticky;
		$fell(status[DIV0_S_BIT]) || $fell(status[BADOP_S_BIT])
			|-> $past(st_wr);
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("sticky bit cleared without write");
	property p_restart;
		restart |=> done_o && store_xfer_o && state == ST_IDLE
			&& !start_o;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart re-executed or no store");
	property p_excp;
		(status[INTOVF_BIT] || (status[DIV0_S_BIT] && status[DIV0_M_BIT]))
			|-> exception_o;
	endproperty
	a_excp: assert property (p_excp)
		else $error("exception not raised");
	property p_dec_inf;
		ce_i && dec_operand_i[3:0] == SIGN_NINF |=> dec_class_o.neg_inf
			&& !dec_class_o.number && dec_clean_o[DEC_WIDTH-1:DEC_USED] == '0;
	endproperty
	a_dec_inf: assert property (p_dec_inf)
		else $error("decimal minus infinity misdecoded");

	c_restart: cover property (restart);
	c_unord: cover property (res_take && cur_cmp && res_flags_i.unordered);
	c_dec_qnan: cover property (dec_class_o.quiet_nan && !dec_class_o.negative);

endmodule // fp_status_ctrl

// *** sim/dp_model.sv ***
// Datapath stand-in that answers each started operation with flags.
// Assumes start_i is a one-cycle pulse, seen at the falling edge.
`timescale 1ns/1ps
module dp_model
	import fp_status_pkg::*;
(
	input  wire logic       clk_i,
	input  wire res_flags_t flags_i,
	input  wire logic       start_i,
	output logic            res_valid_o,
	output res_flags_t      res_flags_o
);
	// ------------------------------------------------------------
	// Answer after a fixed latency
	// ------------------------------------------------------------
	initial begin
		res_valid_o = 1'b0;
		res_flags_o = '1;
		forever begin
			// A restart never reaches the datapath, so only starts answer
			@(negedge clk_i iff start_i === 1'b1);
			repeat (4) @(negedge clk_i);
			res_valid_o = 1'b1;
			res_flags_o = flags_i;
			@(negedge clk_i);
			res_valid_o = 1'b0;
			// Stale flags must not look valid once the strobe drops
			res_flags_o = ~flags_i;
		end
	end
endmodule // dp_model

// *** sim/fp_status_ctrl_bench.sv ***
// Self-checking bench for the status register and operand decode.
// Assumes the datapath model answers every start after four cycles.
`timescale 1ns/1ps
module fp_status_ctrl_bench;
	import fp_status_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [2:0]  REV  = 3'h3;
	localparam logic [31:0] REVB = {28'h0, REV, 1'b0};
	logic        clk_i = 0, rst_n_i = 0, ce_i = 1, cmd_valid_i = 0;
	logic        mis_i = 0, wf_i = 0;
	op_t         cmd_op_i = OP_NOP;
	logic [31:0] cmd_data_i = '0, int_op = '0, rdata_o;
	logic [95:0] dec_op = '0, dec_clean_o;
	res_flags_t  dp_flags = '0, res_flags_i;
	logic        res_valid_i, rdata_valid_o, start_o, done_o;
	logic        store_xfer_o, exception_o, int_neg_o, int_zero_o;
	logic [1:0]  rounding_sel_o;
	cond_flags_t cond_flags_o;
	dec_class_t  dec_class_o;
	logic        sv_start, sv_done, sv_store, sv_rv;
	int          err_total = 0, check_count = 0, cycles = 0;

	fp_status_ctrl #(.REVISION(REV)) uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_data_i(cmd_data_i), .res_valid_i(res_valid_i),
		.res_flags_i(res_flags_i), .misaligned_fault_i(mis_i),
		.write_fault_i(wf_i), .dec_operand_i(dec_op),
		.int_operand_i(int_op), .rdata_o(rdata_o),
		.rdata_valid_o(rdata_valid_o), .start_o(start_o),
		.done_o(done_o), .store_xfer_o(store_xfer_o),
		.exception_o(exception_o), .rounding_sel_o(rounding_sel_o),
		.cond_flags_o(cond_flags_o), .dec_class_o(dec_class_o),
		.dec_clean_o(dec_clean_o), .int_neg_o(int_neg_o),
		.int_zero_o(int_zero_o)
	);
	dp_model u_dp (
		.clk_i(clk_i), .flags_i(dp_flags), .start_i(start_o),
		.res_valid_o(res_valid_i), .res_flags_o(res_flags_i)
	);

	always #50 clk_i = ~clk_i;

	// A hang shows as a run far beyond the 150 or so cycles needed
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [95:0] seen,
		input logic [95:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Pulses are captured in the cycle after the taking edge
	task automatic cmd(input op_t op, input logic [31:0] d);
		cmd_valid_i = 1;
		cmd_op_i = op;
		cmd_data_i = d;
		@(negedge clk_i);
		sv_start = start_o;
		sv_done = done_o;
		sv_store = store_xfer_o;
		sv_rv = rdata_valid_o;
		cmd_valid_i = 0;
		@(negedge clk_i);
	endtask

	task automatic rd(input logic [31:0] m, input logic [31:0] exp);
		cmd(OP_STATUS_READ, 32'h0);
		chk("rvalid", sv_rv, 1);
		chk("status", rdata_o & m, exp);
	endtask

	task automatic wait_done();
		for (int i = 0; i < 20 && done_o !== 1'b1; i++)
			@(negedge clk_i);
		chk("done", done_o, 1);
	endtask

	task automatic run(input op_t op, input logic [10:0] f);
		dp_flags = f;
		cmd(op, 32'h0);
		chk("start", sv_start, 1);
		wait_done();
	endtask

	task automatic ev(input bit w);
		if (w)
			wf_i = 1;
		else
			mis_i = 1;
		@(negedge clk_i);
		wf_i = 0;
		mis_i = 0;
		@(negedge clk_i);
	endtask

	function automatic logic [5:0] cls(input logic [3:0] s);
		if (s == 4'h0) return 6'h20;
		if (s == 4'h1) return 6'h10;
		if (s == 4'h2) return 6'h08;
		if (s == 4'h3) return 6'h09;
		if (s <= 4'h9) return 6'h04;
		return (s == 4'hb || s == 4'hd) ? 6'h03 : 6'h02;
	endfunction

	// Garbage above the digits must come back as zero
	task automatic dchk(input logic [3:0] s, input logic [3:0] top,
		input logic [5:0] exp, input logic [5:0] m);
		dec_op = {20'hfffff, top, 68'h23456789012345678, s};
		@(negedge clk_i);
		chk("class", dec_class_o & m, exp & m);
		chk("clean", dec_clean_o, {20'h0, dec_op[75:0]});
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1;
		rd('1, 32'h8000_0000 | REVB);
		ce_i = 0;
		cmd(OP_STATUS_WRITE, 32'h0);
		ce_i = 1;
		rd('1, 32'h8000_0000 | REVB);
		cmd(OP_STATUS_WRITE, '1);
		rd('1, (WRITE_MASK | REVB) | 32'h0200_0000);
		chk("exc", exception_o, 1);
		for (int r = 0; r < 4; r++) begin
			cmd(OP_STATUS_WRITE, 32'(r) << 22);
			chk("rsel", rounding_sel_o, r[1:0]);
		end
		cmd(OP_STATUS_WRITE, 32'h0);
		rd('1, REVB);
		chk("exc", exception_o, 0);
		dp_flags = 11'h780;
		cmd(OP_ARITH, 32'h0);
		chk("start", sv_start, 1);
		cmd(OP_ARITH, 32'h0);
		chk("start", sv_start, 0);
		rd(32'h8002_0000, 32'h0002_0000);
		wait_done();
		rd('1, 32'h8036_0080 | REVB);
		chk("cond", cond_flags_o, 4'hd);
		run(OP_ARITH, 11'h000);
		rd('1, 32'h8006_0080 | REVB);
		run(OP_COMPARE, 11'h004);
		rd('1, 32'h8007_0080 | REVB);
		chk("cond", cond_flags_o, 4'h1);
		run(OP_COMPARE, 11'h000);
		chk("cond", cond_flags_o, 4'h0);
		rd(32'h0001_0000, 32'h0);
		cmd(OP_STATUS_WRITE, 32'h0000_1000);
		chk("exc", exception_o, 0);
		run(OP_ARITH, 11'h080);
		chk("exc", exception_o, 1);
		cmd(OP_STATUS_WRITE, 32'h0000_0080);
		chk("exc", exception_o, 0);
		cmd(OP_STATUS_WRITE, 32'h0);
		run(OP_CONV_INT, 11'h002);
		rd('1, 32'h820a_0000 | REVB);
		chk("exc", exception_o, 1);
		// Zero divisor alone, without a finite nonzero dividend, is no divide fault
		run(OP_ARITH, 11'h010);
		rd(32'h0008_0040, 32'h0008_0000);
		cmd(OP_STATUS_WRITE, 32'h0100_0000);
		run(OP_ARITH, 11'h078);
		rd('1, 32'h8302_0340 | REVB);
		cmd(OP_STATUS_WRITE, 32'h0);
		ev(0);
		ev(1);
		rd('1, REVB);
		cmd(OP_STATUS_WRITE, 32'h1);
		ev(0);
		rd('1, 32'h11 | REVB);
		ev(1);
		rd('1, 32'h8011 | REVB);
		cmd(OP_NOP, 32'h0);
		chk("done", sv_done, 0);
		rd('1, 32'h8011 | REVB);
		cmd(OP_ARITH, 32'h0);
		chk("done", sv_done, 1);
		chk("store", sv_store, 1);
		chk("start", sv_start, 0);
		rd(32'h7fff_ffff, 32'h2_0011 | REVB);
		for (int s = 0; s < 16; s++)
			dchk(s[3:0], 4'h1, cls(s[3:0]),
				(s < 2 || (s > 3 && s < 10)) ? 6'h3e : 6'h3f);
		dchk(4'hc, 4'ha, 6'h08, 6'h3f);
		dchk(4'h5, 4'hf, 6'h04, 6'h3e);
		int_op = 32'h8000_0000;
		@(negedge clk_i);
		chk("ineg", {int_neg_o, int_zero_o}, 2'b10);
		int_op = 32'h0;
		@(negedge clk_i);
		chk("izero", {int_neg_o, int_zero_o}, 2'b01);
		stop_test();
	end
endmodule // fp_status_ctrl_bench
